// File: common/opd_consts.svh
`ifndef OPD_CONSTS_SVH
`define OPD_CONSTS_SVH

// Register byte addresses (page 0)
`define OPD_A_PAGE    8'h00
`define OPD_A_SWRST   8'h04
`define OPD_A_OUTCFG  8'h08
`define OPD_A_PWR     8'h0C
`define OPD_A_DELAY   8'h10
`define OPD_A_PDCFG   8'h14
`define OPD_A_LVL01   8'h18
`define OPD_A_LVL23   8'h1C
`define OPD_A_SCCTL   8'h20
`define OPD_A_SCSTAT  8'h24
`define OPD_A_HSTYPE  8'h28
`define OPD_A_GPCFG   8'h2C
`define OPD_A_GPRT    8'h30
`define OPD_A_ISTAT   8'h34
`define OPD_A_IMASK   8'h38
`define OPD_A_GPIN    8'h3C

// Reset values
`define OPD_RST_BYTE  8'h00
`define OPD_RST_PDCFG 8'h04
`define OPD_RST_SCCTL 8'h01

// Field positions
`define OPD_PAGE_BIT   0
`define OPD_SWRST_BIT  7
`define OPD_SOFT_BIT   2
`define OPD_LIMIT_BIT  0
`define OPD_AUTO_BIT   1
`define OPD_TRAIN_BIT0 6

// Level codes and attenuation
`define OPD_GAIN_MAX    4'h9
`define OPD_ATTEN_START 6'h3F
`define OPD_ATTEN_ZERO  6'h00

// Timing, in ns
`define OPD_CLK_NS    40
`define OPD_MS_NS     1000000
`define OPD_STEP_NS   500000
`define OPD_PULSE_NS  2000
`define OPD_TRAIN_NS  8000

// Power-up delay choices, in ms
`define OPD_DLY_MS_0  0
`define OPD_DLY_MS_1  10
`define OPD_DLY_MS_2  50
`define OPD_DLY_MS_3  100
`define OPD_DLY_MS_4  500
`define OPD_DLY_MS_5  1000
`define OPD_DLY_MS_6  2000
`define OPD_DLY_MS_7  4000

`endif

// File: common/opd_pkg.sv
package opd_pkg;

  typedef struct packed {
    logic       on;
    logic       ready;
    logic [1:0] pd_mode;
    logic [5:0] atten;
    logic [3:0] gain;
  } opd_drv_ctl_t;

  typedef struct packed {
    logic agc;
    logic short_ckt;
    logic button;
    logic jack;
  } opd_evt_t;

  typedef enum logic [1:0] {
    OPD_PD_TRISTATE,
    OPD_PD_VCM_WEAK,
    OPD_PD_HALF_SUPPLY,
    OPD_PD_RSVD
  } opd_pd_mode_t;

  typedef enum logic [1:0] {
    OPD_GP_INPUT,
    OPD_GP_OUTPUT,
    OPD_GP_CLOCK,
    OPD_GP_IRQ
  } opd_gp_mode_t;

  typedef enum {
    OPD_CH_OFF,
    OPD_CH_DELAY,
    OPD_CH_STEP,
    OPD_CH_ON
  } opd_ch_state_t;

endpackage

// File: rtl/opd_drv_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "opd_consts.svh"

module opd_drv_chan
  import opd_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = 25000,
  parameter int unsigned STEP_CYCLES = 12500
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        en,
  input  wire logic [2:0]  delay_sel,
  input  wire logic [1:0]  pd_mode,
  input  wire logic        soft_en,
  input  wire logic [3:0]  gain,
  input  wire logic        short_det,
  input  wire logic        auto_off,
  output opd_drv_ctl_t     ctl,
  output logic             tripped
);

  opd_ch_state_t state_q;
  logic [31:0]   cnt_q;
  logic [5:0]    atten_q;
  logic          run;
  logic [31:0]   dly_cycles;

  always_comb begin
    case (delay_sel)
      3'h0:    dly_cycles = 32'(`OPD_DLY_MS_0 * MS_CYCLES);
      3'h1:    dly_cycles = 32'(`OPD_DLY_MS_1 * MS_CYCLES);
      3'h2:    dly_cycles = 32'(`OPD_DLY_MS_2 * MS_CYCLES);
      3'h3:    dly_cycles = 32'(`OPD_DLY_MS_3 * MS_CYCLES);
      3'h4:    dly_cycles = 32'(`OPD_DLY_MS_4 * MS_CYCLES);
      3'h5:    dly_cycles = 32'(`OPD_DLY_MS_5 * MS_CYCLES);
      3'h6:    dly_cycles = 32'(`OPD_DLY_MS_6 * MS_CYCLES);
      default: dly_cycles = 32'(`OPD_DLY_MS_7 * MS_CYCLES);
    endcase
  end

  assign run = en & ~tripped;

  // Latched shutdown holds until software removes the power enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tripped <= 1'b0;
    end else if (!en) begin
      tripped <= 1'b0;
    end else if (auto_off && short_det && state_q != OPD_CH_OFF) begin
      tripped <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= OPD_CH_OFF;
      cnt_q   <= '0;
      atten_q <= `OPD_ATTEN_START;
    end else begin
      case (state_q)
        OPD_CH_OFF: begin
          atten_q <= `OPD_ATTEN_START;
          if (run) begin
            cnt_q   <= dly_cycles;
            state_q <= OPD_CH_DELAY;
          end
        end
        OPD_CH_DELAY: begin
          if (!run) begin
            state_q <= OPD_CH_OFF;
          end else if (cnt_q == '0) begin
            atten_q <= soft_en ? `OPD_ATTEN_START : `OPD_ATTEN_ZERO;
            cnt_q   <= 32'(STEP_CYCLES);
            state_q <= OPD_CH_STEP;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        OPD_CH_STEP: begin
          if (!run) begin
            state_q <= OPD_CH_OFF;
          end else if (atten_q == `OPD_ATTEN_ZERO) begin
            state_q <= OPD_CH_ON;
          end else if (cnt_q == '0) begin
            atten_q <= atten_q - 6'h1;
            cnt_q   <= 32'(STEP_CYCLES);
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        default: begin
          if (!run) begin
            state_q <= OPD_CH_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl <= '{on: 1'b0, ready: 1'b0, pd_mode: 2'h0, atten: `OPD_ATTEN_START, gain: 4'h0};
    end else begin
      ctl.on      <= (state_q != OPD_CH_OFF) && run;
      ctl.ready   <= (state_q == OPD_CH_ON) && run;
      ctl.pd_mode <= (pd_mode == OPD_PD_RSVD) ? OPD_PD_TRISTATE : pd_mode;
      ctl.atten   <= atten_q;
      ctl.gain    <= (gain > `OPD_GAIN_MAX) ? `OPD_GAIN_MAX : gain;
    end
  end

endmodule

`default_nettype wire

// File: rtl/opd_gpio_pin.sv
`timescale 1ns/1ps
`default_nettype none
`include "opd_consts.svh"

module opd_gpio_pin
  import opd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [1:0]  mode,
  input  wire logic        out_level,
  input  wire logic        train_en,
  input  wire logic        irq_src,
  input  wire logic        clk_div,
  output logic             pin_out,
  output logic             pin_oe
);

  localparam int unsigned PULSE_CYC = (`OPD_PULSE_NS + `OPD_CLK_NS - 1) / `OPD_CLK_NS;
  localparam int unsigned TRAIN_CYC = (`OPD_TRAIN_NS + `OPD_CLK_NS - 1) / `OPD_CLK_NS;

  logic        src_d1_q;
  logic [15:0] pcnt_q;
  logic [15:0] phase_q;
  logic        irq_wave;

  // One pulse per new interrupt, or a train while the cause stays latched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_d1_q <= 1'b0;
      pcnt_q   <= '0;
      phase_q  <= '0;
    end else begin
      src_d1_q <= irq_src;
      if (irq_src && !src_d1_q) begin
        pcnt_q <= 16'(PULSE_CYC);
      end else if (pcnt_q != '0) begin
        pcnt_q <= pcnt_q - 16'h1;
      end
      if (!irq_src || !train_en || phase_q == 16'(TRAIN_CYC - 1)) begin
        phase_q <= '0;
      end else begin
        phase_q <= phase_q + 16'h1;
      end
    end
  end

  assign irq_wave = train_en ? (irq_src && phase_q < 16'(PULSE_CYC)) : (pcnt_q != '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      case (mode)
        OPD_GP_INPUT: begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b0;
        end
        OPD_GP_OUTPUT: begin
          pin_out <= out_level;
          pin_oe  <= 1'b1;
        end
        OPD_GP_CLOCK: begin
          pin_out <= clk_div;
          pin_oe  <= 1'b1;
        end
        default: begin
          pin_out <= irq_wave;
          pin_oe  <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: rtl/opd_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "opd_consts.svh"

module opd_top
  import opd_pkg::*;
#(
  parameter int unsigned N_DRV       = 4,
  parameter int unsigned N_GPIO      = 2,
  parameter int unsigned MS_CYCLES   = `OPD_MS_NS / `OPD_CLK_NS,
  parameter int unsigned STEP_CYCLES = `OPD_STEP_NS / `OPD_CLK_NS
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output opd_drv_ctl_t [N_DRV-1:0] drv_ctl,
  output logic [7:0]              output_config,
  output logic                    active_page,
  input  wire logic [N_DRV-1:0]   short_det,
  input  wire logic               jack_present,
  input  wire logic [1:0]         headset_type,
  input  wire logic               button_press,
  input  wire logic               agc_noise,
  input  wire logic [N_GPIO-1:0]  gpio_in,
  output logic [N_GPIO-1:0]       gpio_out,
  output logic [N_GPIO-1:0]       gpio_oe,
  output logic                    irq
);

  logic       ph_valid_q;
  logic       ph_write_q;
  logic [7:0] ph_addr_q;
  logic       rd_pend_q;
  logic       sw_rst_q;
  logic       wr_en;
  logic       wr_p0;
  logic [7:0] wd;
  logic [7:0] rd_data;
  logic       rd_istat;

  logic [7:0] outcfg_q;
  logic [7:0] pwr_q;
  logic [7:0] delay_q;
  logic [7:0] pdcfg_q;
  logic [7:0] lvl01_q;
  logic [7:0] lvl23_q;
  logic [7:0] scctl_q;
  logic [7:0] gpcfg_q;
  logic [7:0] gprt_q;
  logic [7:0] imask_q;
  logic [3:0] istat_q;
  logic [7:0] hstype_q;
  logic [N_GPIO-1:0] gpin_q;

  opd_evt_t          evt;
  opd_evt_t          prev_q;
  logic [N_DRV-1:0]  short_d1_q;
  logic [N_DRV-1:0]  tripped;
  logic [N_DRV-1:0]  prot_active;
  logic [15:0]       lvl_all;
  logic              clk_div_q;
  logic              seen_q;

  // Bus address phase and one wait state on reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
      rd_pend_q  <= 1'b0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        ph_valid_q <= hwrite;
        ph_write_q <= hwrite;
        ph_addr_q  <= haddr[7:0];
        rd_pend_q  <= !hwrite;
        hreadyout  <= hwrite;
      end else begin
        ph_valid_q <= 1'b0;
        rd_pend_q  <= 1'b0;
        if (rd_pend_q) begin
          hrdata    <= {24'h00_0000, rd_data};
          hreadyout <= 1'b1;
        end
      end
    end
  end

  assign wr_en    = ph_valid_q && ph_write_q;
  assign wr_p0    = wr_en && !active_page;
  assign wd       = hwdata[7:0];
  assign rd_istat = rd_pend_q && !active_page && ph_addr_q == `OPD_A_ISTAT;

  // Page bit; page 1 holds nothing here, so its accesses read zero except the page register itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_page <= 1'b0;
    end else if (sw_rst_q) begin
      active_page <= 1'b0;
    end else if (wr_en && ph_addr_q == `OPD_A_PAGE) begin
      active_page <= wd[`OPD_PAGE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= wr_p0 && ph_addr_q == `OPD_A_SWRST && wd[`OPD_SWRST_BIT];
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outcfg_q <= `OPD_RST_BYTE;
      pwr_q    <= `OPD_RST_BYTE;
      delay_q  <= `OPD_RST_BYTE;
      pdcfg_q  <= `OPD_RST_PDCFG;
      lvl01_q  <= `OPD_RST_BYTE;
      lvl23_q  <= `OPD_RST_BYTE;
      scctl_q  <= `OPD_RST_SCCTL;
      gpcfg_q  <= `OPD_RST_BYTE;
      gprt_q   <= `OPD_RST_BYTE;
      imask_q  <= `OPD_RST_BYTE;
    end else if (sw_rst_q) begin
      outcfg_q <= `OPD_RST_BYTE;
      pwr_q    <= `OPD_RST_BYTE;
      delay_q  <= `OPD_RST_BYTE;
      pdcfg_q  <= `OPD_RST_PDCFG;
      lvl01_q  <= `OPD_RST_BYTE;
      lvl23_q  <= `OPD_RST_BYTE;
      scctl_q  <= `OPD_RST_SCCTL;
      gpcfg_q  <= `OPD_RST_BYTE;
      gprt_q   <= `OPD_RST_BYTE;
      imask_q  <= `OPD_RST_BYTE;
    end else if (wr_p0) begin
      if (ph_addr_q == `OPD_A_OUTCFG) begin
        outcfg_q <= wd;
      end else if (ph_addr_q == `OPD_A_PWR) begin
        pwr_q <= wd;
      end else if (ph_addr_q == `OPD_A_DELAY) begin
        delay_q <= wd;
      end else if (ph_addr_q == `OPD_A_PDCFG) begin
        pdcfg_q <= wd;
      end else if (ph_addr_q == `OPD_A_LVL01) begin
        lvl01_q <= wd;
      end else if (ph_addr_q == `OPD_A_LVL23) begin
        lvl23_q <= wd;
      end else if (ph_addr_q == `OPD_A_SCCTL) begin
        scctl_q <= wd;
      end else if (ph_addr_q == `OPD_A_GPCFG) begin
        gpcfg_q <= wd;
      end else if (ph_addr_q == `OPD_A_GPRT) begin
        gprt_q <= wd;
      end else if (ph_addr_q == `OPD_A_IMASK) begin
        imask_q <= wd;
      end
    end
  end

  // Input sampling and event history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q     <= '0;
      short_d1_q <= '0;
      hstype_q   <= 8'h00;
      gpin_q     <= '0;
    end else begin
      prev_q     <= '{agc: agc_noise, short_ckt: 1'b0, button: button_press, jack: jack_present};
      short_d1_q <= short_det;
      hstype_q   <= {5'h00, jack_present, headset_type};
      gpin_q     <= gpio_in;
    end
  end

  // Divided clock offered to the pins in clock mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= !clk_div_q;
    end
  end

  // History is valid only after one sample; a plug present at reset is no event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  assign prot_active   = short_det & {N_DRV{scctl_q[`OPD_LIMIT_BIT]}};
  assign evt.jack      = seen_q && (jack_present ^ prev_q.jack);
  assign evt.button    = button_press && !prev_q.button;
  assign evt.short_ckt = |(short_det & ~short_d1_q);
  assign evt.agc       = agc_noise && !prev_q.agc;

  // Sticky causes: an event in the clearing cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q <= 4'h0;
    end else if (sw_rst_q) begin
      istat_q <= 4'h0;
    end else if (rd_istat) begin
      istat_q <= evt;
    end else if (wr_p0 && ph_addr_q == `OPD_A_ISTAT) begin
      istat_q <= (istat_q & ~wd[3:0]) | evt;
    end else begin
      istat_q <= istat_q | evt;
    end
  end

  // Level interrupt; the mask hides a cause without clearing it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_q & imask_q[3:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_config <= 8'h00;
    end else begin
      output_config <= outcfg_q;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (ph_addr_q == `OPD_A_PAGE) begin
      rd_data = {7'h00, active_page};
    end else if (active_page) begin
      rd_data = 8'h00;
    end else if (ph_addr_q == `OPD_A_OUTCFG) begin
      rd_data = outcfg_q;
    end else if (ph_addr_q == `OPD_A_PWR) begin
      rd_data = pwr_q;
    end else if (ph_addr_q == `OPD_A_DELAY) begin
      rd_data = delay_q;
    end else if (ph_addr_q == `OPD_A_PDCFG) begin
      rd_data = pdcfg_q;
    end else if (ph_addr_q == `OPD_A_LVL01) begin
      rd_data = lvl01_q;
    end else if (ph_addr_q == `OPD_A_LVL23) begin
      rd_data = lvl23_q;
    end else if (ph_addr_q == `OPD_A_SCCTL) begin
      rd_data = scctl_q;
    end else if (ph_addr_q == `OPD_A_SCSTAT) begin
      rd_data = {tripped, prot_active};
    end else if (ph_addr_q == `OPD_A_HSTYPE) begin
      rd_data = hstype_q;
    end else if (ph_addr_q == `OPD_A_GPCFG) begin
      rd_data = gpcfg_q;
    end else if (ph_addr_q == `OPD_A_GPRT) begin
      rd_data = gprt_q;
    end else if (ph_addr_q == `OPD_A_ISTAT) begin
      rd_data = {4'h0, istat_q};
    end else if (ph_addr_q == `OPD_A_IMASK) begin
      rd_data = imask_q;
    end else if (ph_addr_q == `OPD_A_GPIN) begin
      rd_data = 8'(gpin_q);
    end
  end

  assign lvl_all = {lvl23_q, lvl01_q};

  genvar gi;
  generate
    for (gi = 0; gi < N_DRV; gi++) begin : g_drv
      opd_drv_chan #(
        .MS_CYCLES   (MS_CYCLES),
        .STEP_CYCLES (STEP_CYCLES)
      ) u_chan (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .en        (pwr_q[gi]),
        .delay_sel (delay_q[2:0]),
        .pd_mode   (pdcfg_q[1:0]),
        .soft_en   (pdcfg_q[`OPD_SOFT_BIT]),
        .gain      (lvl_all[gi*4 +: 4]),
        .short_det (short_det[gi]),
        .auto_off  (scctl_q[`OPD_AUTO_BIT]),
        .ctl       (drv_ctl[gi]),
        .tripped   (tripped[gi])
      );
    end
    for (gi = 0; gi < N_GPIO; gi++) begin : g_gpio
      opd_gpio_pin u_pin (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .mode      (gpcfg_q[gi*2 +: 2]),
        .out_level (gpcfg_q[4 + gi]),
        .train_en  (gpcfg_q[`OPD_TRAIN_BIT0 + gi]),
        .irq_src   (|(istat_q & gprt_q[gi*4 +: 4])),
        .clk_div   (clk_div_q),
        .pin_out   (gpio_out[gi]),
        .pin_oe    (gpio_oe[gi])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// File: tb/opd_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module opd_load_model (
  input  wire logic       plug_in,
  input  wire logic [1:0] plug_kind,
  input  wire logic [3:0] short_req,
  input  wire logic       press,
  input  wire logic       noise,
  input  wire logic [1:0] ext_lvl,
  input  wire logic [1:0] gpio_out,
  input  wire logic [1:0] gpio_oe,
  output logic [3:0]      short_det,
  output logic            jack_present,
  output logic [1:0]      headset_type,
  output logic            button_press,
  output logic            agc_noise,
  output logic [1:0]      gpio_in
);
  // Pulling the plug grounds the left driver pin through the jack spring
  assign short_det = short_req | {3'h0, !plug_in};
  assign jack_present = plug_in;
  assign headset_type = plug_in ? plug_kind : 2'h0;
  assign button_press = press & plug_in;
  assign agc_noise = noise;
  // Pin level: device drive wins, otherwise the outside source
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
endmodule
`default_nettype wire

// File: tb/opd_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module opd_top_assertions
  import opd_pkg::*;
#(
  parameter int unsigned N_DRV = 4
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic                    hready,
  input  wire logic                    hreadyout,
  input  wire logic [31:0]             hrdata,
  input  wire opd_drv_ctl_t [N_DRV-1:0] drv_ctl
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];

  a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write was stretched");
  a_rdata_byte_only: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the low byte");
  a_ready_needs_on: assert property (drv_ctl[0].ready |-> drv_ctl[0].on)
    else $error("driver ready while unpowered");
  a_ready_unattenuated: assert property (drv_ctl[0].ready |-> drv_ctl[0].atten == 6'h00)
    else $error("driver ready with attenuation left");
  a_gain_within_max: assert property (drv_ctl[0].gain <= 4'h9)
    else $error("driver gain above maximum");
  a_pd_mode_legal: assert property (drv_ctl[0].pd_mode != 2'h3)
    else $error("driver in an undefined powered-down state");
  a_atten_only_falls: assert property (
    drv_ctl[0].on && $past(drv_ctl[0].on) |-> drv_ctl[0].atten <= $past(drv_ctl[0].atten))
    else $error("attenuation rose while powered");
endmodule

bind opd_top opd_top_assertions #(.N_DRV(N_DRV)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .drv_ctl(drv_ctl));
`default_nettype wire

// File: tb/opd_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "opd_consts.svh"
module opd_top_test;
  import opd_pkg::*;
  localparam int MSC  = 4;
  localparam int STC  = 2;
  localparam int RAMP = `OPD_DLY_MS_1 * MSC + 63 * (STC + 1);
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] exp;} opd_row_t;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0;
  logic               hreadyout, hresp, active_page, irq;
  logic [31:0]        hrdata;
  opd_drv_ctl_t [3:0] drv_ctl;
  logic [7:0]         output_config, rd;
  logic [1:0]         gpio_out, gpio_oe, gpio_in, headset_type;
  logic [1:0]         plug_kind = 2'h2;
  logic [1:0]         ext_lvl = 2'h1;
  logic [3:0]         short_det;
  logic [3:0]         short_req = 4'h0;
  logic               jack_present, button_press, agc_noise;
  logic               press = 1'b0;
  logic               plug = 1'b1;
  logic               p1;
  int                 mismatches = 0;
  int                 samples_checked = 0;
  int                 n, hi0, up1;
  opd_row_t           rows [15] = '{
    '{1'b0, `OPD_A_PAGE,   8'h00, 8'h00},
    '{1'b0, `OPD_A_PDCFG,  8'h00, 8'h04},
    '{1'b0, `OPD_A_SCCTL,  8'h00, 8'h01},
    '{1'b0, `OPD_A_SWRST,  8'h00, 8'h00},
    '{1'b0, `OPD_A_HSTYPE, 8'h00, 8'h06},
    '{1'b0, `OPD_A_GPIN,   8'h00, 8'h01},
    '{1'b1, `OPD_A_OUTCFG, 8'hA5, 8'h00},
    '{1'b0, `OPD_A_OUTCFG, 8'h00, 8'hA5},
    '{1'b1, `OPD_A_LVL01,  8'h95, 8'h00},
    '{1'b0, `OPD_A_LVL01,  8'h00, 8'h95},
    '{1'b1, 8'h40,         8'hFF, 8'h00},
    '{1'b0, 8'h40,         8'h00, 8'h00},
    '{1'b1, `OPD_A_IMASK,  8'h0F, 8'h00},
    '{1'b0, `OPD_A_IMASK,  8'h00, 8'h0F},
    '{1'b0, `OPD_A_SCSTAT, 8'h00, 8'h00}};

  always #20 hclk = ~hclk;

  opd_top #(.MS_CYCLES(MSC), .STEP_CYCLES(STC)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .drv_ctl(drv_ctl),
    .output_config(output_config), .active_page(active_page), .short_det(short_det),
    .jack_present(jack_present), .headset_type(headset_type), .button_press(button_press),
    .agc_noise(agc_noise), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .irq(irq));

  opd_load_model i_load (
    .plug_in(plug), .plug_kind(plug_kind), .short_req(short_req), .press(press),
    .noise(1'b0), .ext_lvl(ext_lvl), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .short_det(short_det), .jack_present(jack_present), .headset_type(headset_type),
    .button_press(button_press), .agc_noise(agc_noise), .gpio_in(gpio_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task automatic watch(input int k);
    hi0 = 0;
    up1 = 0;
    p1 = 1'b0;
    for (int i = 0; i < k; i++) begin
      @(posedge hclk);
      if (i == 3) press <= 1'b0;
      hi0 += gpio_out[0];
      if (gpio_out[1] && !p1) up1++;
      p1 = gpio_out[1];
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    mismatches++;
    complete_run();
  end

  initial begin
    cyc(16);
    hresetn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) check($sformatf("reg %h", rows[i].a), rd, rows[i].exp);
    end
    check("outcfg pins", output_config, 8'hA5);
    check("okay resp", hresp, 1'b0);
    $display("test table done");
    bus(1'b1, `OPD_A_PAGE, 8'h01);
    rdchk("page readback", `OPD_A_PAGE, 8'h01);
    check("page pin", active_page, 1'b1);
    rdchk("page1 hides", `OPD_A_OUTCFG, 8'h00);
    bus(1'b1, `OPD_A_PAGE, 8'h00);
    bus(1'b1, `OPD_A_SWRST, 8'h80);
    cyc(2);
    rdchk("outcfg soft", `OPD_A_OUTCFG, 8'h00);
    rdchk("imask soft", `OPD_A_IMASK, 8'h00);
    rdchk("swrst self clear", `OPD_A_SWRST, 8'h00);
    $display("test page and soft reset done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `OPD_A_PDCFG, 8'(m) | 8'h04);
      cyc(2);
      check("pd mode", drv_ctl[0].pd_mode, (m == 3) ? 0 : m);
    end
    bus(1'b1, `OPD_A_LVL01, 8'h0F);
    bus(1'b1, `OPD_A_DELAY, 8'h01);
    bus(1'b1, `OPD_A_OUTCFG, 8'h3C);
    bus(1'b1, `OPD_A_PWR, 8'h01);
    n = 0;
    while (drv_ctl[0].ready !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    check("ramp length", n >= RAMP && n <= RAMP + 11, 1'b1);
    check("ramp atten", drv_ctl[0].atten, `OPD_ATTEN_ZERO);
    check("gain clamp", drv_ctl[0].gain, `OPD_GAIN_MAX);
    check("other off", drv_ctl[1].on, 1'b0);
    $display("test power up done");
    bus(1'b1, `OPD_A_SCCTL, 8'h03);
    short_req <= 4'h1;
    cyc(4);
    rdchk("short active", `OPD_A_SCSTAT, 8'h11);
    check("auto off", drv_ctl[0].on, 1'b0);
    short_req <= 4'h0;
    cyc(4);
    check("stays off", drv_ctl[0].on, 1'b0);
    rdchk("flag held", `OPD_A_SCSTAT, 8'h10);
    bus(1'b1, `OPD_A_PWR, 8'h00);
    bus(1'b1, `OPD_A_PWR, 8'h01);
    rdchk("flag cleared", `OPD_A_SCSTAT, 8'h00);
    cyc(3);
    check("back on", drv_ctl[0].on, 1'b1);
    $display("test short done");
    bus(1'b1, `OPD_A_GPCFG, 8'h25);
    cyc(2);
    check("gp oe", gpio_oe, 2'h3);
    check("gp out", gpio_out, 2'h2);
    rdchk("gp in", `OPD_A_GPIN, 8'h02);
    bus(1'b1, `OPD_A_GPCFG, 8'h0A);
    cyc(1);
    watch(8);
    check("gp clock high", hi0, 4);
    check("gp clock rises", up1, 4);
    bus(1'b1, `OPD_A_ISTAT, 8'h0F);
    bus(1'b1, `OPD_A_GPRT, 8'h2F);
    bus(1'b1, `OPD_A_GPCFG, 8'h8F);
    bus(1'b1, `OPD_A_IMASK, 8'h0F);
    press <= 1'b1;
    watch(500);
    check("single pulse", hi0, 32'(`OPD_PULSE_NS / `OPD_CLK_NS));
    check("train pulses", up1, 3);
    check("irq level", irq, 1'b1);
    rdchk("cause", `OPD_A_ISTAT, 8'h02);
    cyc(3);
    check("irq cleared", irq, 1'b0);
    watch(300);
    check("train stopped", up1, 0);
    bus(1'b1, `OPD_A_IMASK, 8'h00);
    press <= 1'b1;
    watch(8);
    check("masked irq", irq, 1'b0);
    rdchk("masked cause", `OPD_A_ISTAT, 8'h02);
    rdchk("read clears", `OPD_A_ISTAT, 8'h00);
    plug <= 1'b0;
    cyc(3);
    check("unplug off", drv_ctl[0].on, 1'b0);
    rdchk("unplug type", `OPD_A_HSTYPE, 8'h00);
    rdchk("unplug causes", `OPD_A_ISTAT, 8'h05);
    $display("test interrupts done");
    bus(1'b1, `OPD_A_PAGE, 8'h01);
    hresetn <= 1'b0;
    cyc(2);
    check("reset outputs", {hreadyout, active_page, drv_ctl[0].on, irq}, 4'h8);
    hresetn <= 1'b1;
    cyc(1);
    rdchk("page after reset", `OPD_A_PAGE, 8'h00);
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
